// [hw/hibbc_sync.sv]
`timescale 1ns/1ps
module hibbc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    hibbc_sync_if.filter port
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] clean_reg;
    logic [W-1:0] agree;

    // s1 only feeds s2; a change counts once s2 and s3 agree
    assign agree = ~(s2_reg ^ s3_reg);
    assign port.clean = clean_reg;

    always_ff @(posedge port.clk)
    begin
        if (port.rst)
        begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            clean_reg <= INIT;
        end
        else
        begin
            s1_reg <= port.raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            clean_reg <= (s2_reg & agree) | (clean_reg & ~agree);
        end
    end
endmodule

// [hw/hibbc_top.sv]
`timescale 1ns/1ps
`include "hibbc_params.svh"
module hibbc_top
    import hibbc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_clk_link,
    input wire logic i_supply_good,
    input wire logic i_connect_n,
    input wire logic i_backplane_sda,
    input wire logic i_backplane_scl,
    input wire logic i_card_sda,
    input wire logic i_card_scl,
    output logic o_backplane_sda,
    output logic o_backplane_sda_oe,
    output logic o_backplane_scl,
    output logic o_backplane_scl_oe,
    output logic o_card_sda,
    output logic o_card_sda_oe,
    output logic o_card_scl,
    output logic o_card_scl_oe,
    output logic o_ready,
    output logic o_ready_oe,
    output logic o_precharge_en
);

    // one side of a line is pulled low only for a low that came from the far side;
    // recent own drive is masked so the echo through the synchroniser cannot latch
    function automatic logic drive_next(
        input logic conn,
        input logic drv_this,
        input logic recent_this,
        input logic low_this,
        input logic recent_other,
        input logic low_other
    );
        drive_next = conn & low_other & ~recent_other & (drv_this | recent_this | ~low_this);
    endfunction

    function automatic logic both_high(input logic a, input logic b);
        both_high = a & b;
    endfunction

    localparam logic [`HIBBC_IDLE_CNT_W-1:0] IDLE_LAST = `HIBBC_IDLE_CNT_W'(`HIBBC_IDLE_CYCLES - 1);

    // link clock domain
    logic link_rst_meta;
    logic link_rst_reg;
    logic conn_en_reg;

    hibbc_sync_if #(.W(`HIBBC_LINK_IN_W)) link_if ();
    hibbc_sync_if #(.W(`HIBBC_SYS_IN_W)) sys_if ();

    assign link_if.clk = i_clk_link;
    assign link_if.rst = link_rst_reg;
    assign link_if.raw = {conn_en_reg, i_card_scl, i_card_sda, i_backplane_scl, i_backplane_sda};

    hibbc_sync #(.W(`HIBBC_LINK_IN_W), .INIT(`HIBBC_LINK_IN_INIT)) u_link_sync (
        .port (link_if.filter)
    );

    // reset reaches the link domain through two link flops, no reset on them
    always_ff @(posedge i_clk_link)
    begin
        link_rst_meta <= i_rst;
        link_rst_reg <= link_rst_meta;
    end

    wire bp_sda_hi = link_if.clean[`HIBBC_LI_BP_SDA];
    wire bp_scl_hi = link_if.clean[`HIBBC_LI_BP_SCL];
    wire card_sda_hi = link_if.clean[`HIBBC_LI_CARD_SDA];
    wire card_scl_hi = link_if.clean[`HIBBC_LI_CARD_SCL];
    wire link_conn = link_if.clean[`HIBBC_LI_CONN];

    logic prev_sda_reg;
    logic prev_scl_reg;
    logic [`HIBBC_IDLE_CNT_W-1:0] idle_cnt_reg;
    logic idle_reg;
    logic stop_tgl_reg;
    logic card_high_reg;

    logic drv_bp_sda_reg;
    logic drv_bp_scl_reg;
    logic drv_card_sda_reg;
    logic drv_card_scl_reg;
    logic [`HIBBC_ECHO_DEPTH-1:0] hist_bp_sda_reg;
    logic [`HIBBC_ECHO_DEPTH-1:0] hist_bp_scl_reg;
    logic [`HIBBC_ECHO_DEPTH-1:0] hist_card_sda_reg;
    logic [`HIBBC_ECHO_DEPTH-1:0] hist_card_scl_reg;
    logic od_level_reg;

    wire stop_seen = bp_sda_hi & ~prev_sda_reg & bp_scl_hi & prev_scl_reg; // see (R11)
    wire bp_high = both_high(bp_sda_hi, bp_scl_hi);
    wire idle_hit = bp_high & (idle_cnt_reg == IDLE_LAST);

    wire rec_bp_sda = drv_bp_sda_reg | (|hist_bp_sda_reg);
    wire rec_bp_scl = drv_bp_scl_reg | (|hist_bp_scl_reg);
    wire rec_card_sda = drv_card_sda_reg | (|hist_card_sda_reg);
    wire rec_card_scl = drv_card_scl_reg | (|hist_card_scl_reg);

    // drive only while joined; with no connection all four line pins are released
    wire drv_bp_sda_next = drive_next(link_conn, drv_bp_sda_reg, rec_bp_sda, ~bp_sda_hi,
                                      rec_card_sda, ~card_sda_hi); // see (R8) (R9) (R1)
    wire drv_card_sda_next = drive_next(link_conn, drv_card_sda_reg, rec_card_sda, ~card_sda_hi,
                                        rec_bp_sda, ~bp_sda_hi); // see (R8) (R9) (R1)
    wire drv_bp_scl_next = drive_next(link_conn, drv_bp_scl_reg, rec_bp_scl, ~bp_scl_hi,
                                      rec_card_scl, ~card_scl_hi); // see (R8) (R9) (R1)
    wire drv_card_scl_next = drive_next(link_conn, drv_card_scl_reg, rec_card_scl, ~card_scl_hi,
                                        rec_bp_scl, ~bp_scl_hi); // see (R8) (R9) (R1)

    always_ff @(posedge i_clk_link)
    begin
        if (link_rst_reg)
        begin
            prev_sda_reg <= 1'b1;
            prev_scl_reg <= 1'b1;
            idle_cnt_reg <= '0;
            idle_reg <= 1'b0;
            stop_tgl_reg <= 1'b0;
            card_high_reg <= 1'b0;
        end
        else
        begin
            prev_sda_reg <= bp_sda_hi;
            prev_scl_reg <= bp_scl_hi;
            // any low restarts the count; idle holds while both stay high
            if (!bp_high)
                idle_cnt_reg <= '0; // see (R12)
            else if (!idle_hit && !idle_reg)
                idle_cnt_reg <= idle_cnt_reg + 1'b1; // see (R12)
            idle_reg <= bp_high & (idle_reg | idle_hit); // see (R12)
            stop_tgl_reg <= stop_tgl_reg ^ stop_seen; // see (R5)
            card_high_reg <= both_high(card_sda_hi, card_scl_hi); // see (R6)
        end
    end

    always_ff @(posedge i_clk_link)
    begin
        if (link_rst_reg)
        begin
            drv_bp_sda_reg <= 1'b0;
            drv_bp_scl_reg <= 1'b0;
            drv_card_sda_reg <= 1'b0;
            drv_card_scl_reg <= 1'b0;
            hist_bp_sda_reg <= '0;
            hist_bp_scl_reg <= '0;
            hist_card_sda_reg <= '0;
            hist_card_scl_reg <= '0;
            od_level_reg <= 1'b0;
        end
        else
        begin
            drv_bp_sda_reg <= drv_bp_sda_next;
            drv_bp_scl_reg <= drv_bp_scl_next;
            drv_card_sda_reg <= drv_card_sda_next;
            drv_card_scl_reg <= drv_card_scl_next;
            hist_bp_sda_reg <= {hist_bp_sda_reg[`HIBBC_ECHO_DEPTH-2:0], drv_bp_sda_reg};
            hist_bp_scl_reg <= {hist_bp_scl_reg[`HIBBC_ECHO_DEPTH-2:0], drv_bp_scl_reg};
            hist_card_sda_reg <= {hist_card_sda_reg[`HIBBC_ECHO_DEPTH-2:0], drv_card_sda_reg};
            hist_card_scl_reg <= {hist_card_scl_reg[`HIBBC_ECHO_DEPTH-2:0], drv_card_scl_reg};
            od_level_reg <= 1'b0;
        end
    end

    assign o_backplane_sda = od_level_reg;
    assign o_backplane_scl = od_level_reg;
    assign o_card_sda = od_level_reg;
    assign o_card_scl = od_level_reg;
    assign o_backplane_sda_oe = drv_bp_sda_reg;
    assign o_backplane_scl_oe = drv_bp_scl_reg;
    assign o_card_sda_oe = drv_card_sda_reg;
    assign o_card_scl_oe = drv_card_scl_reg;

    // system clock domain
    assign sys_if.clk = i_clk_sys;
    assign sys_if.rst = i_rst;
    assign sys_if.raw = {card_high_reg, idle_reg, stop_tgl_reg, i_connect_n, i_supply_good};

    hibbc_sync #(.W(`HIBBC_SYS_IN_W), .INIT(`HIBBC_SYS_IN_INIT)) u_sys_sync (
        .port (sys_if.filter)
    );

    wire supply_good = sys_if.clean[`HIBBC_SI_SUPPLY_GOOD];
    wire connect_n = sys_if.clean[`HIBBC_SI_CONNECT_N];
    wire idle_seen = sys_if.clean[`HIBBC_SI_IDLE];
    wire card_high = sys_if.clean[`HIBBC_SI_CARD_HIGH];

    hibbc_state_type state_reg;
    hibbc_state_type state_next;
    logic stop_tgl_prev_reg;
    logic ready_oe_reg;
    logic ready_level_reg;
    logic precharge_reg;

    wire stop_evt = sys_if.clean[`HIBBC_SI_STOP_TGL] ^ stop_tgl_prev_reg;
    // a stop seen while sense is high is dropped; the idle level still frees the wait
    wire bus_done = ~connect_n & (stop_evt | idle_seen); // see (R5) (R10)

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            HIBBC_LOCKOUT:
                if (supply_good)
                    state_next = HIBBC_WAIT_BUS; // see (R3)
            HIBBC_WAIT_BUS:
                if (bus_done)
                    state_next = HIBBC_WAIT_CARD; // see (R5)
            HIBBC_WAIT_CARD:
                if (connect_n)
                    state_next = HIBBC_WAIT_BUS; // see (R1)
                else if (card_high)
                    state_next = HIBBC_JOINED; // see (R6) (R7)
            HIBBC_JOINED:
                if (connect_n)
                    state_next = HIBBC_WAIT_BUS; // see (R1) (R10)
            default:
                state_next = HIBBC_LOCKOUT;
        endcase
        if (!supply_good)
            state_next = HIBBC_LOCKOUT; // see (R3)
    end

    wire joined_next = (state_next == HIBBC_JOINED);

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            state_reg <= HIBBC_LOCKOUT;
            stop_tgl_prev_reg <= 1'b0;
            conn_en_reg <= 1'b0;
            ready_oe_reg <= 1'b1;
            ready_level_reg <= 1'b0;
            precharge_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            stop_tgl_prev_reg <= sys_if.clean[`HIBBC_SI_STOP_TGL];
            conn_en_reg <= joined_next; // see (R7) (R1)
            ready_oe_reg <= ~joined_next; // see (R2) (R10)
            ready_level_reg <= 1'b0;
            precharge_reg <= (state_next == HIBBC_LOCKOUT); // see (R4)
        end
    end

    assign o_ready = ready_level_reg;
    assign o_ready_oe = ready_oe_reg;
    assign o_precharge_en = precharge_reg;

endmodule

// [include/hibbc_params.svh]
// Contract
// (R1) connection sense high breaks both line paths and pulls ready low
// (R2) ready is open drain, released only when sense low and start-up done
// (R3) pin activity ignored during supply lockout; leave it only on supply good
// (R4) precharge drive stays enabled on all four lines during lockout
// (R5) after lockout wait for a backplane stop or bus idle
// (R6) after stop or idle also require both card lines high
// (R7) lockout over, stop or idle seen, card high: join card to backplane
// (R8) while joined a low on either side is driven onto the other side
// (R9) while joined a line rises only when both sides release it; code lets the side that began the low rise until the echo mask clears
// (R10) after sense returns low redo the start-up wait, release ready on joining
// (R11) stop is backplane data rising while backplane clock high, synced samples
// (R12) idle is both backplane lines high for a counted interval, any low restarts
`ifndef HIBBC_PARAMS_SVH
`define HIBBC_PARAMS_SVH

`define HIBBC_LINK_PERIOD_NS 48
`define HIBBC_IDLE_TIME_NS 95000
`define HIBBC_IDLE_CYCLES ((`HIBBC_IDLE_TIME_NS + `HIBBC_LINK_PERIOD_NS - 1) / `HIBBC_LINK_PERIOD_NS)
`define HIBBC_IDLE_CNT_W 11
`define HIBBC_ECHO_DEPTH 4

`define HIBBC_LINK_IN_W 5
`define HIBBC_LI_BP_SDA 0
`define HIBBC_LI_BP_SCL 1
`define HIBBC_LI_CARD_SDA 2
`define HIBBC_LI_CARD_SCL 3
`define HIBBC_LI_CONN 4
`define HIBBC_LINK_IN_INIT 5'h0f

`define HIBBC_SYS_IN_W 5
`define HIBBC_SI_SUPPLY_GOOD 0
`define HIBBC_SI_CONNECT_N 1
`define HIBBC_SI_STOP_TGL 2
`define HIBBC_SI_IDLE 3
`define HIBBC_SI_CARD_HIGH 4
`define HIBBC_SYS_IN_INIT 5'h02

`endif

// [include/hibbc_pkg.sv]
package hibbc_pkg;

    typedef enum logic [3:0] {
        HIBBC_LOCKOUT   = 4'h1,
        HIBBC_WAIT_BUS  = 4'h2,
        HIBBC_WAIT_CARD = 4'h4,
        HIBBC_JOINED    = 4'h8
    } hibbc_state_type;

endpackage

// [include/hibbc_sync_if.sv]
`timescale 1ns/1ps
interface hibbc_sync_if #(parameter int W = 1);
    logic clk;
    logic rst;
    logic [W-1:0] raw;
    logic [W-1:0] clean;

    modport filter (input clk, input rst, input raw, output clean);
    modport user (output clk, output rst, output raw, input clean);
endinterface

// [testbench/hibbc_bus_model.sv]
`timescale 1ns/1ps
module hibbc_bus_model (
    input wire logic i_bp_sda_low,
    input wire logic i_bp_scl_low,
    input wire logic i_card_sda_low,
    input wire logic i_card_scl_low,
    input wire logic i_bp_sda_oe,
    input wire logic i_bp_scl_oe,
    input wire logic i_card_sda_oe,
    input wire logic i_card_scl_oe,
    output logic o_bp_sda,
    output logic o_bp_scl,
    output logic o_card_sda,
    output logic o_card_scl
);
    // wired-and with pull-ups, settles at once so the echo mask holds
    assign o_bp_sda = !(i_bp_sda_low || i_bp_sda_oe);
    assign o_bp_scl = !(i_bp_scl_low || i_bp_scl_oe);
    assign o_card_sda = !(i_card_sda_low || i_card_sda_oe);
    assign o_card_scl = !(i_card_scl_low || i_card_scl_oe);
endmodule

// [testbench/hibbc_top_asserts.sv]
`timescale 1ns/1ps
module hibbc_top_asserts (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_clk_link,
    input wire logic i_supply_good,
    input wire logic i_connect_n,
    input wire logic i_backplane_scl,
    input wire logic i_card_sda,
    input wire logic o_backplane_sda,
    input wire logic o_backplane_scl,
    input wire logic o_backplane_sda_oe,
    input wire logic o_backplane_scl_oe,
    input wire logic o_card_sda,
    input wire logic o_card_sda_oe,
    input wire logic o_card_scl,
    input wire logic o_card_scl_oe,
    input wire logic o_ready,
    input wire logic o_ready_oe,
    input wire logic o_precharge_en
);
    // cycles that sense or lockout have held, saturating
    logic [4:0] cn_reg;
    logic [4:0] sl_reg;
    logic any_oe;
    assign any_oe = o_backplane_sda_oe | o_backplane_scl_oe | o_card_sda_oe | o_card_scl_oe;
    always_ff @(posedge i_clk_sys)
    begin
        cn_reg <= (i_rst || !i_connect_n) ? 5'h00 : cn_reg + {4'h0, cn_reg != 5'h1f};
        sl_reg <= (i_rst || i_supply_good) ? 5'h00 : sl_reg + {4'h0, sl_reg != 5'h1f};
    end
    a_ready_open_drain: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_ready == 1'b0) else $error("ready drive value not low");
    a_sense_ready: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        cn_reg >= 5'h08 |-> o_ready_oe) else $error("ready released while sense high");
    a_sense_isolate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        cn_reg >= 5'h10 |-> !any_oe) else $error("line driven while sense high");
    a_lockout_precharge: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        sl_reg >= 5'h08 |-> o_precharge_en && o_ready_oe) else $error("no precharge in lockout");
    a_lockout_quiet: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        sl_reg >= 5'h10 |-> !any_oe) else $error("line driven in lockout");
    a_precharge_not_ready: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_precharge_en |-> o_ready_oe) else $error("ready released during precharge");
    a_drive_zero: assert property (@(posedge i_clk_link) disable iff (i_rst)
        !o_card_sda && !o_backplane_scl && !o_backplane_sda && !o_card_scl)
        else $error("line drive value not low");
    a_release_card_sda: assert property (@(posedge i_clk_link) disable iff (i_rst)
        i_card_sda [*8] |-> !o_backplane_sda_oe) else $error("backplane data held after release");
    a_release_bp_scl: assert property (@(posedge i_clk_link) disable iff (i_rst)
        i_backplane_scl [*8] |-> !o_card_scl_oe) else $error("card clock held after release");
    a_mirror_cause: assert property (@(posedge i_clk_link) disable iff (i_rst)
        $rose(o_backplane_sda_oe) |-> !($past(i_card_sda, 3) && $past(i_card_sda, 4)
        && $past(i_card_sda, 5) && $past(i_card_sda, 6))) else $error("backplane data driven without cause");
    c_joined: cover property (@(posedge i_clk_sys) $fell(o_ready_oe));
    c_card_drive: cover property (@(posedge i_clk_link) $rose(o_card_scl_oe));
    c_bp_drive: cover property (@(posedge i_clk_link) $rose(o_backplane_sda_oe));
endmodule
bind hibbc_top hibbc_top_asserts u_hibbc_top_asserts (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_clk_link(i_clk_link), .i_supply_good(i_supply_good), .i_connect_n(i_connect_n),
    .i_backplane_scl(i_backplane_scl), .i_card_sda(i_card_sda), .o_backplane_sda(o_backplane_sda),
    .o_backplane_scl(o_backplane_scl), .o_backplane_sda_oe(o_backplane_sda_oe),
    .o_backplane_scl_oe(o_backplane_scl_oe), .o_card_sda(o_card_sda), .o_card_sda_oe(o_card_sda_oe),
    .o_card_scl(o_card_scl), .o_card_scl_oe(o_card_scl_oe), .o_ready(o_ready), .o_ready_oe(o_ready_oe),
    .o_precharge_en(o_precharge_en));

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, lclk = 0, rst = 1, sup = 0, cn = 0;
    logic bsd_l = 0, bsc_l = 0, csd_l = 0, csc_l = 0;
    logic bsd, bsc, csd, csc, bsd_oe, bsc_oe, csd_oe, csc_oe, rdy_oe, pre;
    int bad_count = 0, total_checks = 0;
    initial forever #25 clk = ~clk;
    initial
    begin
        #7;
        forever #24 lclk = ~lclk;
    end
    hibbc_top u_hibbc_top (.i_clk_sys(clk), .i_rst(rst), .i_clk_link(lclk), .i_supply_good(sup),
        .i_connect_n(cn), .i_backplane_sda(bsd), .i_backplane_scl(bsc), .i_card_sda(csd),
        .i_card_scl(csc), .o_backplane_sda(), .o_backplane_sda_oe(bsd_oe), .o_backplane_scl(),
        .o_backplane_scl_oe(bsc_oe), .o_card_sda(), .o_card_sda_oe(csd_oe), .o_card_scl(),
        .o_card_scl_oe(csc_oe), .o_ready(), .o_ready_oe(rdy_oe), .o_precharge_en(pre));
    hibbc_bus_model u_hibbc_bus_model (.i_bp_sda_low(bsd_l), .i_bp_scl_low(bsc_l),
        .i_card_sda_low(csd_l), .i_card_scl_low(csc_l), .i_bp_sda_oe(bsd_oe), .i_bp_scl_oe(bsc_oe),
        .i_card_sda_oe(csd_oe), .i_card_scl_oe(csc_oe), .o_bp_sda(bsd), .o_bp_scl(bsc),
        .o_card_sda(csd), .o_card_scl(csc));
    task automatic chk(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic summarize;
        if (bad_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // activity during lockout must not reach the other side
    task automatic t_lockout;
        bsc_l <= 1;
        cyc(20);
        chk("precharge", 1'b1, pre);
        chk("ready_oe", 1'b1, rdy_oe);
        chk("card_scl_oe", 1'b0, csc_oe);
        bsc_l <= 0;
    endtask
    // stop seen while card clock low: join only once card is high
    task automatic t_join;
        sup <= 1;
        csc_l <= 1;
        cyc(10);
        chk("precharge", 1'b0, pre);
        bsd_l <= 1;
        cyc(10);
        bsd_l <= 0;
        cyc(40);
        chk("ready_oe", 1'b1, rdy_oe);
        csc_l <= 0;
        for (int n = 0; n < 60 && rdy_oe !== 1'b0; n++) cyc(1);
        chk("ready_oe", 1'b0, rdy_oe);
    endtask
    // lows mirrored both ways; a side that lets go while the far side holds is pulled low again
    task automatic t_mirror;
        csd_l <= 1;
        cyc(10);
        chk("bp_sda", 1'b0, bsd);
        csd_l <= 0;
        cyc(10);
        chk("bp_sda", 1'b1, bsd);
        bsc_l <= 1;
        cyc(10);
        chk("card_scl", 1'b0, csc);
        csc_l <= 1;
        cyc(5);
        bsc_l <= 0;
        cyc(20);
        chk("bp_scl", 1'b0, bsc);
        csc_l <= 0;
        cyc(20);
        chk("bp_scl", 1'b1, bsc);
        chk("card_scl", 1'b1, csc);
    endtask
    // sense high isolates; reconnect waits for a fresh idle
    // the stop made while sense is still high must be dropped, so sense falls well after it
    task automatic t_sense;
        cn <= 1;
        cyc(12);
        chk("ready_oe", 1'b1, rdy_oe);
        bsd_l <= 1;
        cyc(10);
        chk("card_sda", 1'b1, csd);
        bsd_l <= 0;
        cyc(20);
        cn <= 0;
        cyc(1720);
        chk("ready_oe", 1'b1, rdy_oe);
        for (int n = 0; n < 400 && rdy_oe !== 1'b0; n++) cyc(1);
        chk("ready_oe", 1'b0, rdy_oe);
    endtask
    // supply loss from joined falls back to lockout
    task automatic t_drop;
        sup <= 0;
        cyc(20);
        chk("precharge", 1'b1, pre);
        chk("ready_oe", 1'b1, rdy_oe);
        bsc_l <= 1;
        cyc(10);
        chk("card_scl_oe", 1'b0, csc_oe);
        bsc_l <= 0;
    endtask
    initial
    begin
        cyc(8);
        rst <= 0;
        t_lockout();
        t_join();
        t_mirror();
        t_sense();
        t_drop();
        summarize();
    end
    initial
    begin
        #400us;
        bad_count++;
        summarize();
    end
endmodule
